/* hdl/clock_power_pkg.sv */
/*
  Shared definitions for the clock and power-mode control block: special-function
  register addresses, field positions, reset values, mode encodings, timing counts
  and the external bus bundle.
  Assumes one oscillator-rate clock and a synchronous active-high reset.
*/
package clock_power_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] SFR_ADDR_POWER_MODE    = 8'h87;
  localparam logic [7:0] SFR_ADDR_CLOCK_CONTROL = 8'hf9;

  // ****************************************
  // power_mode_control fields
  // ****************************************
  localparam int PMC_IDLE_BIT     = 0;
  localparam int PMC_PD_BIT       = 1;
  localparam int PMC_TX_SEL_BIT   = 2;
  localparam int PMC_RX_SEL_BIT   = 3;
  localparam int PMC_POR_BIT      = 4;
  localparam int PMC_BAUD1_BIT    = 6;
  localparam int PMC_BAUD0_BIT    = 7;
  localparam logic [7:0] PMC_RESET = 8'h00;

  // ****************************************
  // clock_control_reg fields
  // ****************************************
  localparam int CCR_PRESCALE_LSB = 0;
  localparam int CCR_PRESCALE_MSB = 2;
  localparam int CCR_AUTO_BIT     = 3;
  localparam int CCR_DBGCMP_BIT   = 4;
  localparam logic [7:0] CCR_RESET = 8'h10;

  // ****************************************
  // Prescaler codes and divider
  // ****************************************
  typedef enum logic [2:0] {
    PRESCALE_DIV1    = 3'h0,
    PRESCALE_DIV2    = 3'h1,
    PRESCALE_DIV4    = 3'h2,
    PRESCALE_DIV8    = 3'h3,
    PRESCALE_DIV16   = 3'h4,
    PRESCALE_DIV32   = 3'h5,
    PRESCALE_DIV1024 = 3'h6,
    PRESCALE_DIV2048 = 3'h7
  } prescale_t;
  localparam int DIV_CNT_W = 11;

  // ****************************************
  // Power modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN        = 2'b00,
    MODE_IDLE       = 2'b01,
    MODE_POWER_DOWN = 2'b10,
    MODE_RESTART    = 2'b11
  } power_mode_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MACHINE_CYCLE_TICKS    = 4;
  localparam int RESTART_MACHINE_CYCLES = 3;
  localparam int RESTART_TICKS          = RESTART_MACHINE_CYCLES * MACHINE_CYCLE_TICKS;
  localparam int RESTART_CNT_W          = 4;

  // ****************************************
  // External bus bundle
  // ****************************************
  typedef struct packed {
    logic       ale;
    logic       program_fetch_strobe_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] ad;
    logic       ad_oe;
    logic [7:0] addr_hi;
  } ext_bus_t;

  localparam ext_bus_t BUS_PARKED = '{
    ale:                    1'b0,
    program_fetch_strobe_n: 1'b1,
    rd_n:                   1'b1,
    wr_n:                   1'b1,
    ad:                     8'hff,
    ad_oe:                  1'b1,
    addr_hi:                8'hff
  };

endpackage : clock_power_pkg

/* hdl/core_clock_divider.sv */
/*
  Free-running divider that issues one-cycle enable pulses at the oscillator rate
  divided by the selected prescaler ratio.
  Assumes the caller stops it with run_i while all clocks are to be stopped.
*/
module core_clock_divider
  import clock_power_pkg::*;
(
  // Clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      rst_i,
  // Control
  input  wire logic      run_i,
  input  wire prescale_t prescale_i,
  // Enable out
  output logic           tick_o
);

  logic [DIV_CNT_W-1:0] cnt_q;
  logic [DIV_CNT_W-1:0] mask;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (run_i) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  always_comb begin
    case (prescale_i)
      PRESCALE_DIV1:    mask = 11'h000;
      PRESCALE_DIV2:    mask = 11'h001;
      PRESCALE_DIV4:    mask = 11'h003;
      PRESCALE_DIV8:    mask = 11'h007;
      PRESCALE_DIV16:   mask = 11'h00f;
      PRESCALE_DIV32:   mask = 11'h01f;
      PRESCALE_DIV1024: mask = 11'h3ff;
      PRESCALE_DIV2048: mask = 11'h7ff;
      default:          mask = 11'h000;
    endcase
  end

  // divided tick, ratio may change any time
  assign tick_o = run_i & ((cnt_q & mask) == mask);

endmodule : core_clock_divider

/* hdl/ext_bus_park.sv */
/*
  Registered external bus driver that passes the core's bus through while running
  and parks it at fixed levels during either sleep mode.
  Assumes the core bus bundle comes from logic on the same clock.
*/
module ext_bus_park
  import clock_power_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk_i,
  input  wire logic     rst_i,
  // Control
  input  wire logic     sleep_i,
  // Bus
  input  wire ext_bus_t core_bus_i,
  output ext_bus_t      ext_bus_o
);

  ext_bus_t bus_q;

  // park levels in both sleep modes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_PARKED;
    end else if (sleep_i) begin
      bus_q <= BUS_PARKED;
    end else begin
      bus_q <= core_bus_i;
    end
  end

  assign ext_bus_o = bus_q;

endmodule : ext_bus_park

/* hdl/clock_power_ctrl.sv */
/*
  Clock and power-mode control: core clock prescaler with auto-restore, idle and
  power-down modes, supervisor-reset restart, register port and external bus parking.
  Assumes a 125 MHz oscillator-rate clock, a same-clock register port driven by
  the core, and interrupt requests already qualified by their enables.
*/
// What this block does
// - The core clock is the oscillator divided by a three-bit field rewritable any time.
// - Ratios are undivided, from one half down to one part in 32, then one part in 1024 and in 2048.
// - The prescaler changes no peripheral clock except the watchdog clock.
// - The watchdog is enabled by the same divided tick as the core.
// - With auto-restore set, any interrupt outside power-down forces the prescaler field to zero.
// - Ports hold data in both sleeps; peripherals run in idle and stop in power-down.
// - The watchdog is stopped in idle while the other supervisor resets stay live.
// - In both sleeps the bus parks with latch low, strobes high and both bytes all ones.
// - Writing one to bit 1 of the power register enters power-down; zero means not in it.
// - Writing one to bit 0 of the power register enters idle unless bit 1 is also one; zero means not idling.
// - Bit 6 of the power register doubles the second serial port baud rate.
// - The power register sits at address 87h and resets to 00h, with no sleep active.
// - An enabled interrupt during idle clears the idle bit and resumes the core.
// - Power-down ends only on a pin, low-voltage or debug reset, never the watchdog.
// - A supervisor reset clears idle and restarts the core after three machine cycles.
module clock_power_ctrl
  import clock_power_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic [7:0]      sfr_rdata_o,
  // Events
  input  wire logic       irq_i,
  input  wire logic       ext_reset_n_i,
  input  wire logic       low_voltage_detector_i,
  input  wire logic       debug_reset_i,
  input  wire logic       watchdog_timer_reset_i,
  // Clock enables
  output logic            core_clk_en_o,
  output logic            watchdog_timer_clk_en_o,
  output logic            periph_clk_en_o,
  // Status
  output logic            port_hold_o,
  output logic            supervisor_reset_o,
  output logic            idle_o,
  output logic            power_down_o,
  // Configuration out
  output logic            uart0_baud_double_o,
  output logic            uart1_baud_double_o,
  output logic            uart1_rx_clock_sel_o,
  output logic            uart1_tx_clock_sel_o,
  output logic            debug_cmp_en_o,
  // External bus
  input  wire ext_bus_t   core_bus_i,
  output ext_bus_t        ext_bus_o
);

  // ****************************************
  // Declarations
  // ****************************************
  power_mode_t              mode_q;
  power_mode_t              mode_d;
  logic [RESTART_CNT_W-1:0] restart_q;
  logic [7:0]               pmc_cfg_q;
  logic [7:0]               ccr_q;
  logic [7:0]               rdata_q;
  logic [1:0]               pin_rst_sync_q;
  logic [1:0]               lvd_sync_q;
  logic                     sup_req_q;
  logic                     sup_req;
  logic                     wr_pmc;
  logic                     wr_ccr;
  logic                     div_run;
  logic                     div_tick;
  logic                     sleeping;
  logic                     auto_restore_hit;
  logic [7:0]               pmc_read;
  prescale_t                prescale;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Pin and analog detector are asynchronous to the oscillator clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_rst_sync_q <= 2'h3;
    end else begin
      pin_rst_sync_q <= {pin_rst_sync_q[0], ext_reset_n_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lvd_sync_q <= 2'h0;
    end else begin
      lvd_sync_q <= {lvd_sync_q[0], low_voltage_detector_i};
    end
  end

  // ****************************************
  // Supervisor reset request
  // ****************************************
  // watchdog excluded from sleep exit
  assign sup_req = ~pin_rst_sync_q[1] | lvd_sync_q[1] | debug_reset_i
                 | (watchdog_timer_reset_i & (mode_q == MODE_RUN));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sup_req_q <= 1'b0;
    end else begin
      sup_req_q <= sup_req;
    end
  end

  assign supervisor_reset_o = sup_req_q;

  // ****************************************
  // Register decode
  // ****************************************
  assign wr_pmc = sfr_wr_i & (sfr_addr_i == SFR_ADDR_POWER_MODE);
  assign wr_ccr = sfr_wr_i & (sfr_addr_i == SFR_ADDR_CLOCK_CONTROL);

  // ****************************************
  // Power mode state machine
  // ****************************************
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (wr_pmc && sfr_wdata_i[PMC_PD_BIT]) begin
          mode_d = MODE_POWER_DOWN;
        end else if (wr_pmc && sfr_wdata_i[PMC_IDLE_BIT]) begin
          mode_d = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (irq_i) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_POWER_DOWN: begin
        mode_d = MODE_POWER_DOWN;
      end
      MODE_RESTART: begin
        if (restart_q == '0) begin
          mode_d = MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
    if (sup_req) begin
      mode_d = MODE_RESTART;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ****************************************
  // Restart delay
  // ****************************************
  // three machine cycles of core ticks
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      restart_q <= '0;
    end else if (sup_req) begin
      restart_q <= RESTART_CNT_W'(RESTART_TICKS);
    end else if (mode_q == MODE_RESTART && div_tick && restart_q != '0) begin
      restart_q <= restart_q - 4'h1;
    end
  end

  // ****************************************
  // Configuration bits of power_mode_control
  // ****************************************
  // second port baud doubling held here
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sup_req) begin
      pmc_cfg_q <= PMC_RESET;
    end else if (wr_pmc) begin
      pmc_cfg_q <= sfr_wdata_i;
    end
  end

  assign uart0_baud_double_o  = pmc_cfg_q[PMC_BAUD0_BIT];
  assign uart1_baud_double_o  = pmc_cfg_q[PMC_BAUD1_BIT];
  assign uart1_rx_clock_sel_o = pmc_cfg_q[PMC_RX_SEL_BIT];
  assign uart1_tx_clock_sel_o = pmc_cfg_q[PMC_TX_SEL_BIT];

  // Mode bits read back from the state, bit 5 reads zero
  always_comb begin
    pmc_read                = pmc_cfg_q;
    pmc_read[5]             = 1'b0;
    pmc_read[PMC_IDLE_BIT]  = (mode_q == MODE_IDLE);
    pmc_read[PMC_PD_BIT]    = (mode_q == MODE_POWER_DOWN);
  end

  // ****************************************
  // clock_control_reg
  // ****************************************
  // interrupt outranks a same-cycle write
  assign auto_restore_hit = irq_i & ccr_q[CCR_AUTO_BIT] & (mode_q != MODE_POWER_DOWN);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sup_req) begin
      ccr_q <= CCR_RESET;
    end else begin
      if (wr_ccr) begin
        ccr_q <= {3'h0, sfr_wdata_i[4:0]};
      end
      if (auto_restore_hit) begin
        ccr_q[CCR_PRESCALE_MSB:CCR_PRESCALE_LSB] <= PRESCALE_DIV1;
      end
    end
  end

  assign prescale       = prescale_t'(ccr_q[CCR_PRESCALE_MSB:CCR_PRESCALE_LSB]);
  assign debug_cmp_en_o = ccr_q[CCR_DBGCMP_BIT];

  // ****************************************
  // Register read
  // ****************************************
  // Unmapped addresses read zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        SFR_ADDR_POWER_MODE:    rdata_q <= pmc_read;
        SFR_ADDR_CLOCK_CONTROL: rdata_q <= ccr_q;
        default:                rdata_q <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata_o = rdata_q;

  // ****************************************
  // Clock enables
  // ****************************************
  // All clocks stop in power-down, divider included
  assign div_run = (mode_q != MODE_POWER_DOWN);

  core_clock_divider u_divider (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .run_i      (div_run),
    .prescale_i (prescale),
    .tick_o     (div_tick)
  );

  // Core tick stops in both sleeps and during the restart delay
  assign core_clk_en_o = div_tick & (mode_q == MODE_RUN);

  assign watchdog_timer_clk_en_o = div_tick & (mode_q == MODE_RUN || mode_q == MODE_RESTART);

  // peripherals live in idle, stopped in power-down
  assign periph_clk_en_o = (mode_q != MODE_POWER_DOWN);

  // ****************************************
  // Sleep status and bus parking
  // ****************************************
  assign sleeping     = (mode_q == MODE_IDLE) || (mode_q == MODE_POWER_DOWN);
  assign idle_o       = (mode_q == MODE_IDLE);
  assign power_down_o = (mode_q == MODE_POWER_DOWN);

  assign port_hold_o  = sleeping;

  ext_bus_park u_bus_park (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .sleep_i    (sleeping),
    .core_bus_i (core_bus_i),
    .ext_bus_o  (ext_bus_o)
  );

endmodule : clock_power_ctrl

/* testbench/core_bus_model.sv */
/*
  Stand-in for the processor core's side of the external bus.
  Assumes the core moves its bus only on core clock ticks.
*/
module core_bus_model
  import clock_power_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Core tick
  input  wire logic core_clk_en_i,
  // Bus
  output ext_bus_t  core_bus_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Fresh bus values every tick so a stale pass-through shows up
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      core_bus_o <= BUS_PARKED;
    else if (core_clk_en_i)
      core_bus_o <= ext_bus_t'($urandom);
  end

endmodule : core_bus_model

/* testbench/clock_power_checker.sv */
/*
  Concurrent checks on the clock and power-mode control ports.
  Assumes it is bound into the top module and sees its ports only.
*/
module clock_power_checker
  import clock_power_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // Inputs
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       irq_i,
  input wire logic       ext_reset_n_i,
  input wire logic       low_voltage_detector_i,
  input wire logic       debug_reset_i,
  // Outputs
  input wire logic       core_clk_en_o,
  input wire logic       watchdog_timer_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       port_hold_o,
  input wire logic       supervisor_reset_o,
  input wire logic       idle_o,
  input wire logic       power_down_o,
  input wire logic       uart1_baud_double_o,
  input wire ext_bus_t   ext_bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // ****************
  // Quiet time
  // ****************
  // Synchronised resets stay in flight a few cycles after the pins
  logic       calm;
  logic [4:0] quiet_q;
  assign calm = ext_reset_n_i && !low_voltage_detector_i && !debug_reset_i && !supervisor_reset_o;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      quiet_q <= 5'h1f;
    else if (!calm)
      quiet_q <= 5'h00;
    else if (quiet_q != 5'h1f)
      quiet_q <= quiet_q + 5'h01;
  end

  // ****************
  // Properties
  // ****************
  a_idle_core_off: assert property (idle_o |-> !core_clk_en_o && !watchdog_timer_clk_en_o)
    else $error("core or watchdog tick while idle");
  a_pd_periph_off: assert property (power_down_o |-> !periph_clk_en_o && !core_clk_en_o)
    else $error("clock running in power-down");
  a_idle_periph_on: assert property (idle_o |-> periph_clk_en_o && port_hold_o)
    else $error("peripherals or port hold wrong in idle");
  a_wdt_same_tick: assert property (core_clk_en_o |-> watchdog_timer_clk_en_o)
    else $error("watchdog tick differs from core tick");
  a_bus_parked: assert property ($past(idle_o || power_down_o) && (idle_o || power_down_o)
    |-> ext_bus_o == BUS_PARKED)
    else $error("external bus not parked in sleep");
  a_irq_wakes_idle: assert property (idle_o && irq_i |=> !idle_o)
    else $error("interrupt did not end idle");
  a_pd_holds_on: assert property (power_down_o && calm && quiet_q > 5'h03 |=> power_down_o)
    else $error("power-down left without supervisor reset");
  // Core tick marks the running state, so the write is taken there
  a_pd_write: assert property (quiet_q > 5'h03 && core_clk_en_o && sfr_wr_i
    && sfr_addr_i == 8'h87 && sfr_wdata_i[1] |=> power_down_o && !idle_o)
    else $error("power-down write not taken");
  a_restart_delay: assert property ($fell(supervisor_reset_o)
    |-> !core_clk_en_o [*8] ##[1:8] core_clk_en_o)
    else $error("restart delay wrong");
  a_baud_write: assert property (quiet_q > 5'h0f && sfr_wr_i && sfr_addr_i == 8'h87
    |=> uart1_baud_double_o == $past(sfr_wdata_i[6]))
    else $error("baud double bit not written");

endmodule : clock_power_checker

/* testbench/testbench.sv */
/*
  Self-checking bench for the clock and power-mode control block.
  Assumes the package and the design files are compiled first.
*/
module testbench
  import clock_power_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       sfr_rd_i = 1'b0;
  logic       irq_i = 1'b0;
  logic       ext_reset_n_i = 1'b1;
  logic       low_voltage_detector_i = 1'b0;
  logic       debug_reset_i = 1'b0;
  logic       watchdog_timer_reset_i = 1'b0;
  logic [7:0] sfr_rdata_o, w;
  logic       core_clk_en_o, watchdog_timer_clk_en_o, periph_clk_en_o, port_hold_o;
  logic       supervisor_reset_o, idle_o, power_down_o, uart1_baud_double_o;
  logic       uart0_baud_double_o, uart1_rx_clock_sel_o, uart1_tx_clock_sel_o, debug_cmp_en_o;
  ext_bus_t   core_bus_i, ext_bus_o, bus_exp;
  int         fails = 0;
  int         n_tests = 0;
  int         n;

  always #4 ref_clk_i = ~ref_clk_i;

  clock_power_ctrl DUT (.*);
  core_bus_model u_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .core_clk_en_i(core_clk_en_o), .core_bus_o(core_bus_i));

  // ****************
  // Helpers
  // ****************
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    tick(1);
    sfr_wr_i = 1'b0;
    // Idle edge so a following strobe never rises in the same step
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, exp);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    tick(1);
    sfr_rd_i = 1'b0;
    check("sfr_rdata_o", sfr_rdata_o, exp);
    tick(1);
  endtask : rd

  // Cycles until the next core tick, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (core_clk_en_o !== 1'b1 && c < 4100);
  endtask : gap

  function automatic int div_of(input logic [2:0] c);
    return (c < 3'h6) ? (1 << c) : ((c == 3'h6) ? 1024 : 2048);
  endfunction : div_of

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    fails++;
    wrap_up();
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(32'h3be01080));
    tick(5);
    rst_i = 1'b0;
    rd(8'h87, 8'h00);
    rd(8'hf9, 8'h10);
    rd(8'h55, 8'h00);
    repeat (6) begin
      w = 8'($urandom) & 8'hfc;
      wr(8'h87, w);
      check("uart1_baud_double_o", uart1_baud_double_o, w[6]);
      check("uart0_baud_double_o", uart0_baud_double_o, w[7]);
      check("uart1_rx_clock_sel_o", uart1_rx_clock_sel_o, w[3]);
      check("uart1_tx_clock_sel_o", uart1_tx_clock_sel_o, w[2]);
      rd(8'h87, w & 8'hdc);
    end
    bus_exp = core_bus_i;
    tick(1);
    check("ext_bus_o", ext_bus_o, bus_exp);
    for (int c = 0; c < 8; c++) begin
      wr(8'hf9, 8'(c));
      gap(n);
      gap(n);
      check("core tick period", n, div_of(3'(c)));
      check("periph_clk_en_o", periph_clk_en_o, 1'b1);
      check("debug_cmp_en_o", debug_cmp_en_o, 1'b0);
    end
    for (int a = 0; a < 2; a++) begin
      wr(8'hf9, a[0] ? 8'h1f : 8'h17);
      irq_i = 1'b1;
      tick(1);
      irq_i = 1'b0;
      rd(8'hf9, a[0] ? 8'h18 : 8'h17);
      check("debug_cmp_en_o", debug_cmp_en_o, 1'b1);
    end
    wr(8'hf9, 8'h10);
    for (int s = 0; s < 2; s++) begin
      wr(8'h87, 8'h01);
      check("idle_o", idle_o, 1'b1);
      watchdog_timer_reset_i = 1'b1;
      tick(2);
      watchdog_timer_reset_i = 1'b0;
      check("idle_o", idle_o, 1'b1);
      check("ext_bus_o", ext_bus_o, BUS_PARKED);
      irq_i = (s == 0);
      debug_reset_i = (s == 1);
      tick(1);
      irq_i = 1'b0;
      debug_reset_i = 1'b0;
      check("idle_o", idle_o, 1'b0);
      gap(n);
      check("restart gap", n, (s == 0) ? 1 : 13);
    end
    for (int s = 0; s < 3; s++) begin
      wr(8'h87, 8'h03);
      check("power_down_o", power_down_o, 1'b1);
      check("idle_o", idle_o, 1'b0);
      irq_i = 1'b1;
      watchdog_timer_reset_i = 1'b1;
      tick(4);
      irq_i = 1'b0;
      watchdog_timer_reset_i = 1'b0;
      check("power_down_o", power_down_o, 1'b1);
      check("periph_clk_en_o", periph_clk_en_o, 1'b0);
      ext_reset_n_i = (s != 0);
      low_voltage_detector_i = (s == 1);
      debug_reset_i = (s == 2);
      tick(3);
      ext_reset_n_i = 1'b1;
      low_voltage_detector_i = 1'b0;
      debug_reset_i = 1'b0;
      tick(3);
      check("power_down_o", power_down_o, 1'b0);
      gap(n);
      // Pin and detector resets pass the synchroniser, the debug reset does not
      check("restart gap", n, (s == 2) ? 10 : 12);
      rd(8'h87, 8'h00);
    end
    wrap_up();
  end

endmodule : testbench

bind clock_power_ctrl clock_power_checker u_checker (.*);
